// *** dcdc_params.svh ***
// Constants for the converter mode control block.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef DCDC_PARAMS_SVH
`define DCDC_PARAMS_SVH
`define CLK_PERIOD_NS        10
`define PWM_PERIOD_NS        4000
`define PWM_PERIOD_CYC       ((`PWM_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DUTY_W               8
`define DUTY_MIN             8'h08
`define DUTY_STEP            8'h08
`define DUTY_FULL            8'hff
`define SS_HOLD_PERIODS      4
`define SS_HOLD_W            3
`define EDGE_DEAD_CYC        4
`define STAT_SW_OPEN_BIT     0
`define STAT_SW_SHORT_BIT    1
`define STAT_OUT_WIN_BIT     2
`endif

// *** dcdc_pkg.sv ***
// Types shared by the converter mode control files.
// Constants live in dcdc_params.svh.
package dcdc_pkg;
	typedef enum logic [2:0]
	{
		sys_normal,
		sys_stop,
		sys_restart,
		sys_sleep,
		sys_fail_safe
	} sys_mode_t;

	typedef struct packed
	{
		logic step_up_enable;
		logic step_up_voltage_select;
		logic auto_modulation_enable;
		logic wake_pin_modulation_control;
		logic stop_command;
		logic step_up_active_clear;
		logic converter_status_clear;
	} ctrl_t;

	typedef struct packed
	{
		logic step_up_sense_low;
		logic step_up_sense_above_hys;
		logic step_down_target_reached;
		logic step_down_load_high;
		logic step_down_switch_node_open;
		logic step_down_switch_node_short;
		logic step_down_out_of_window;
		logic wake_input_pin;
	} analog_t;

	typedef struct packed
	{
		logic high_side_on;
		logic low_side_on;
	} bridge_t;
endpackage

// *** step_down_pwm.sv ***
// Fixed-frequency PWM generator with edge-shaped switch sequencing.
// Duty comes from the main controller; one clock, synchronous reset.
`include "dcdc_params.svh"
`timescale 1ns/1ps
module step_down_pwm
#(
	parameter int PERIOD_CYC = `PWM_PERIOD_CYC
)
(
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	input  wire logic                  run,
	input  wire logic [`DUTY_W-1:0]    duty,
	output dcdc_pkg::bridge_t          bridge,
	output logic                       period_end
);
	import dcdc_pkg::*;

	typedef struct packed
	{
		logic [15:0] cnt;
		logic [2:0]  dead;
		logic        want_hi;
		bridge_t     br;
	} pwm_state_t;

	pwm_state_t s;
	pwm_state_t next_s;
	logic [23:0] on_len;
	logic        want;

	always_comb
	begin
		next_s = s;
		on_len = 24'(duty) * 24'(PERIOD_CYC);
		want = 1'b0;
		if (!run)
		begin
			next_s = '0;
		end
		else
		begin
			next_s.cnt = (s.cnt == 16'(PERIOD_CYC - 1)) ? 16'h0000 : s.cnt + 16'h0001;
			// Full duty keeps the high side on for the whole period
			want = (duty == `DUTY_FULL) || ({s.cnt, 8'h00} < on_len);
			next_s.want_hi = want;
			// Both switches off for a dead time on every change
			if (want != s.want_hi)
			begin
				next_s.br = '0;
				next_s.dead = 3'(`EDGE_DEAD_CYC);
			end
			else if (s.dead != 3'h0)
			begin
				next_s.dead = s.dead - 3'h1;
			end
			else
			begin
				next_s.br.high_side_on = s.want_hi;
				next_s.br.low_side_on = !s.want_hi;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign bridge = s.br;
	assign period_end = run && (s.cnt == 16'(PERIOD_CYC - 1));
endmodule

// *** dcdc_mode_control.sv ***
// Mode control for a cascaded step-up / step-down switching regulator.
// Assumes analog comparator inputs are asynchronous and the mode comes from
// a controller on clk_sys; control bits are plain ports.
`include "dcdc_params.svh"
`timescale 1ns/1ps
module dcdc_mode_control
#(
	parameter int SS_HOLD = `SS_HOLD_PERIODS
)
(
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	input  dcdc_pkg::sys_mode_t      sys_mode,
	input  dcdc_pkg::ctrl_t          hardware_control,
	input  dcdc_pkg::analog_t        analog_in,
	input  wire logic [`DUTY_W-1:0]  loop_duty,
	output dcdc_pkg::bridge_t        step_down_switches,
	output logic                     step_down_pfm_pulse,
	output logic                     step_up_gate,
	output logic                     step_up_threshold_select,
	output logic                     regulator_enable,
	output logic                     pwm_selected,
	output logic                     soft_start_busy,
	output logic                     step_up_active_flag,
	output logic [2:0]               converter_status_flags,
	output logic                     light_load_exit_flag,
	output logic                     light_load_exit_event
);
	import dcdc_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef enum
	{
		ss_idle,
		ss_ramp,
		ss_done
	} ss_phase_t;

	typedef struct packed
	{
		analog_t                 sync1;
		analog_t                 sync2;
		sys_mode_t               mode_prev;
		logic                    powered;
		ss_phase_t               ss;
		logic [`DUTY_W-1:0]      ss_duty;
		logic [`SS_HOLD_W-1:0]   ss_hold;
		logic                    stop_pwm;
		logic                    exit_flag;
		logic                    exit_evt;
		logic                    up_gate;
		logic                    up_flag;
		logic [2:0]              stat;
		logic                    pfm_pulse;
		logic                    pwm_sel;
		logic                    en;
	} state_t;

	state_t s;
	state_t next_s;

	bridge_t            pwm_bridge;
	logic               period_end;
	logic [`DUTY_W-1:0] duty;
	logic               pwm_run;

	function automatic logic mode_on(input sys_mode_t m);
		return (m == sys_normal) || (m == sys_stop) || (m == sys_restart);
	endfunction

	function automatic logic wakes_to_restart(input sys_mode_t from, input sys_mode_t to);
		return (to == sys_restart) && ((from == sys_sleep) || (from == sys_fail_safe));
	endfunction

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb
	begin
		analog_t a;
		logic    want_pwm;
		logic    start_ss;
		a = s.sync2;
		want_pwm = 1'b0;
		start_ss = 1'b0;
		next_s = s;
		// First stage feeds only the second
		next_s.sync1 = analog_in;
		next_s.sync2 = s.sync1;
		next_s.mode_prev = sys_mode;
		next_s.exit_evt = 1'b0;

		next_s.en = mode_on(sys_mode);

		// Soft start on first power-up and after wake into restart
		start_ss = (!s.powered && mode_on(sys_mode))
			|| wakes_to_restart(s.mode_prev, sys_mode);
		if (mode_on(sys_mode))
			next_s.powered = 1'b1;

		// ------------------ Stop-mode modulation ------------------
		if (sys_mode == sys_stop && s.mode_prev != sys_stop)
		begin
			next_s.stop_pwm = 1'b0;
		end
		else if (sys_mode == sys_stop && hardware_control.stop_command)
		begin
			next_s.stop_pwm = 1'b0;
		end
		else if (sys_mode == sys_stop && hardware_control.auto_modulation_enable
			&& a.step_down_load_high && !s.stop_pwm
			&& !hardware_control.wake_pin_modulation_control)
		begin
			next_s.stop_pwm = 1'b1;
			next_s.exit_evt = 1'b1;
		end
		else if (sys_mode != sys_stop)
		begin
			next_s.stop_pwm = 1'b0;
		end

		// Exit flag: a new event beats a clear in the same cycle
		if (next_s.exit_evt)
			next_s.exit_flag = 1'b1;
		else if (hardware_control.converter_status_clear)
			next_s.exit_flag = 1'b0;

		unique case (sys_mode)
			sys_normal, sys_restart: want_pwm = 1'b1;
			sys_stop:
			begin
				if (hardware_control.wake_pin_modulation_control)
					want_pwm = a.wake_input_pin;
				else
					want_pwm = s.stop_pwm;
			end
			default: want_pwm = 1'b0;
		endcase
		next_s.pwm_sel = want_pwm && next_s.en;

		// ------------------ Soft start ------------------
		if (!next_s.en)
		begin
			next_s.ss = ss_idle;
		end
		else if (start_ss)
		begin
			next_s.ss = ss_ramp;
			next_s.ss_duty = `DUTY_MIN;
			next_s.ss_hold = '0;
		end
		else if (s.ss == ss_idle)
		begin
			next_s.ss = ss_done;
		end
		else if (s.ss == ss_ramp)
		begin
			if (a.step_down_target_reached)
			begin
				next_s.ss = ss_done;
			end
			else if (period_end)
			begin
				if (s.ss_hold == `SS_HOLD_W'(SS_HOLD - 1))
				begin
					next_s.ss_hold = '0;
					if (s.ss_duty <= `DUTY_FULL - `DUTY_STEP)
						next_s.ss_duty = s.ss_duty + `DUTY_STEP;
					else
						next_s.ss_duty = `DUTY_FULL;
				end
				else
				begin
					next_s.ss_hold = s.ss_hold + `SS_HOLD_W'(1);
				end
			end
		end

		// ------------------ PFM ------------------
		// Pulse straight from the comparator, no period count
		next_s.pfm_pulse = next_s.en && !want_pwm && !a.step_down_target_reached;

		// ------------------ Step-up stage ------------------
		// Step-up gate is hysteretic on/off while enabled, not fixed-frequency PWM
		if (!hardware_control.step_up_enable || !next_s.en)
			next_s.up_gate = 1'b0;
		else if (a.step_up_sense_low)
			next_s.up_gate = 1'b1;
		else if (a.step_up_sense_above_hys)
			next_s.up_gate = 1'b0;

		if (next_s.up_gate && !s.up_gate)
			next_s.up_flag = 1'b1;
		else if (hardware_control.step_up_active_clear && !a.step_up_sense_low)
			next_s.up_flag = 1'b0;

		// ------------------ Status ------------------
		// Flags are sticky; set wins over clear; out-of-window flag only sets while enabled
		if (hardware_control.converter_status_clear)
			next_s.stat = '0;
		next_s.stat[`STAT_SW_OPEN_BIT] = next_s.stat[`STAT_SW_OPEN_BIT]
			| a.step_down_switch_node_open;
		next_s.stat[`STAT_SW_SHORT_BIT] = next_s.stat[`STAT_SW_SHORT_BIT]
			| a.step_down_switch_node_short;
		next_s.stat[`STAT_OUT_WIN_BIT] = next_s.stat[`STAT_OUT_WIN_BIT]
			| (s.en && a.step_down_out_of_window);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.mode_prev <= sys_sleep;
			s.ss <= ss_idle;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ****************************************************************
	// PWM engine
	// ****************************************************************
	// Soft-start duty overrides the loop until the target is reached
	assign duty = (s.ss == ss_ramp) ? s.ss_duty : loop_duty;
	assign pwm_run = s.en && s.pwm_sel;

	step_down_pwm u_pwm
	(
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.run        (pwm_run),
		.duty       (duty),
		.bridge     (pwm_bridge),
		.period_end (period_end)
	);

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign step_down_switches       = pwm_bridge;
	assign step_down_pfm_pulse      = s.pfm_pulse;
	assign step_up_gate             = s.up_gate;
	assign step_up_threshold_select = hardware_control.step_up_voltage_select;
	assign regulator_enable         = s.en;
	assign pwm_selected             = s.pwm_sel;
	assign soft_start_busy          = (s.ss == ss_ramp);
	assign step_up_active_flag      = s.up_flag;
	assign converter_status_flags   = s.stat;
	assign light_load_exit_flag     = s.exit_flag;
	assign light_load_exit_event    = s.exit_evt;
endmodule

// *** mode_ctrl_model.sv ***
// Model of the mode controller and its control register at the far side.
// Bench requests reach the block one clock later, as over a register write.
`timescale 1ns/1ps
module mode_ctrl_model
(
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	input  dcdc_pkg::sys_mode_t mode_req,
	input  dcdc_pkg::ctrl_t     ctrl_req,
	output dcdc_pkg::sys_mode_t sys_mode,
	output dcdc_pkg::ctrl_t     hardware_control
);
	import dcdc_pkg::*;
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			sys_mode <= sys_sleep;
			hardware_control <= '0;
		end
		else
		begin
			sys_mode <= mode_req;
			// Step-up enable and stop reissue only ever come from here
			hardware_control <= ctrl_req;
		end
	end
endmodule

// *** dcdc_mode_control_asserts.sv ***
// Port assertions for the converter mode control block.
// Bound to every instance; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module dcdc_mode_control_asserts
#(
	parameter int SS_HOLD = 4
)
(
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	input  dcdc_pkg::sys_mode_t sys_mode,
	input  dcdc_pkg::ctrl_t     hardware_control,
	input  dcdc_pkg::bridge_t   step_down_switches,
	input  wire logic          step_up_gate,
	input  wire logic          step_up_threshold_select,
	input  wire logic          regulator_enable,
	input  wire logic          pwm_selected,
	input  wire logic          soft_start_busy,
	input  wire logic          step_up_active_flag,
	input  wire logic          light_load_exit_flag,
	input  wire logic          light_load_exit_event
);
	import dcdc_pkg::*;
	logic on_mode;
	logic no_auto;
	assign on_mode = sys_mode inside {sys_normal, sys_stop, sys_restart};
	// Pin control also takes over the automatic exit
	assign no_auto = !hardware_control.auto_modulation_enable
		|| hardware_control.wake_pin_modulation_control;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence low_gap;
		!step_down_switches.low_side_on [*4];
	endsequence
	sequence stop_entry;
		sys_mode == sys_stop && $past(sys_mode) != sys_stop
			&& !hardware_control.wake_pin_modulation_control;
	endsequence
	reg_enable_a: assert property ($past(rst_n) && $past(rst_n, 2)
		|-> regulator_enable == $past(on_mode)) else $error("regulator enable wrong");
	stop_pfm_a: assert property (stop_entry |=> !pwm_selected)
		else $error("stop entry kept pwm");
	normal_pwm_a: assert property (sys_mode == sys_normal
		&& $past(sys_mode) == sys_normal && !soft_start_busy |-> pwm_selected)
		else $error("normal mode not pwm");
	step_up_off_a: assert property (!$past(hardware_control.step_up_enable)
		|-> !step_up_gate) else $error("step-up ran while disabled");
	bridge_excl_a: assert property (!(step_down_switches.high_side_on
		&& step_down_switches.low_side_on)) else $error("both switches on");
	dead_time_a: assert property ($fell(step_down_switches.high_side_on)
		|-> low_gap) else $error("dead time short");
	thresh_sel_a: assert property (step_up_threshold_select
		== hardware_control.step_up_voltage_select) else $error("threshold select wrong");
	// PWM select follows the stored stop modulation, so it lands one cycle after the event
	exit_event_a: assert property (light_load_exit_event
		|-> light_load_exit_flag ##1 (pwm_selected && !light_load_exit_event))
		else $error("exit event malformed");
	auto_off_a: assert property ($past(no_auto) |-> !light_load_exit_event)
		else $error("exit while auto off");
	act_sticky_a: assert property (step_up_active_flag
		&& !hardware_control.step_up_active_clear |=> step_up_active_flag)
		else $error("active flag lost");
	act_set_a: assert property ($rose(step_up_gate) |-> ##[0:1] step_up_active_flag)
		else $error("active flag not set");
endmodule
bind dcdc_mode_control dcdc_mode_control_asserts #(.SS_HOLD(SS_HOLD)) chk (.*);

// *** dcdc_mode_control_tb.sv ***
// Self-checking bench for the converter mode control block.
// Modes and controls go through the controller model; one 100 MHz clock.
`timescale 1ns/1ps
module dcdc_mode_control_tb;
	import dcdc_pkg::*;
`define CHK(o, e) begin total_checks++; if ((o) !== (e)) begin fails++; \
	$display("ERROR t=%0t got %h exp %h", $time, o, e); end end
	logic       clk_sys = 1'b0;
	logic       rst_n = 1'b0;
	sys_mode_t  mode_req = sys_sleep;
	sys_mode_t  sys_mode;
	ctrl_t      ctrl_req = 7'h10;
	ctrl_t      hardware_control;
	analog_t    analog_in = '0;
	logic [7:0] loop_duty = 8'h80;
	bridge_t    sw;
	logic       pfm, gate, thr, en, pwm, ss, act, ll_flag, ll_ev;
	logic [2:0] stat;
	logic [8:0] obs;
	logic [8:0] q_e[$];
	logic [8:0] q_m[$];
	int         fails = 0;
	int         total_checks = 0;
	event       ev_check;
	sys_mode_t  seq_m[6] = '{sys_stop, sys_normal, sys_sleep, sys_restart,
		sys_fail_safe, sys_restart};
	logic [8:0] seq_e[6] = '{9'h080, 9'h0c0, 9'h000, 9'h180, 9'h000, 9'h180};
	logic [8:0] seq_k[6] = '{9'h0c0, 9'h0c0, 9'h080, 9'h180, 9'h080, 9'h180};
	always #5 clk_sys = ~clk_sys;
	assign obs = {ss, en, pwm, gate, act, ll_flag, stat};
	mode_ctrl_model partner (.clk_sys(clk_sys), .rst_n(rst_n), .mode_req(mode_req),
		.ctrl_req(ctrl_req), .sys_mode(sys_mode), .hardware_control(hardware_control));
	dcdc_mode_control #(.SS_HOLD(1)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.sys_mode(sys_mode), .hardware_control(hardware_control), .analog_in(analog_in),
		.loop_duty(loop_duty), .step_down_switches(sw), .step_down_pfm_pulse(pfm),
		.step_up_gate(gate), .step_up_threshold_select(thr), .regulator_enable(en),
		.pwm_selected(pwm), .soft_start_busy(ss), .step_up_active_flag(act),
		.converter_status_flags(stat), .light_load_exit_flag(ll_flag),
		.light_load_exit_event(ll_ev));
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic go(input sys_mode_t md);
		@(posedge clk_sys) mode_req <= md;
	endtask
	task automatic set_c(input int b, input logic v);
		@(posedge clk_sys) ctrl_req[b] <= v;
	endtask
	task automatic set_a(input int b, input logic v);
		@(posedge clk_sys) analog_in[b] <= v;
	endtask
	task automatic pulse(input int b);
		set_c(b, 1'b1);
		set_c(b, 1'b0);
	endtask
	// Outputs land in the edge's update region, so look 1 ns later
	task automatic note(input logic [8:0] m, input logic [8:0] e);
		#1;
		q_m.push_back(m);
		q_e.push_back(e);
		-> ev_check;
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wait_idle;
		for (int i = 0; i < 5000 && ss !== 1'b0; i++)
			@(posedge clk_sys);
		if (ss !== 1'b0)
		begin
			fails++;
			end_of_test();
		end
	endtask
	always @(ev_check)
	begin
		logic [8:0] m;
		logic [8:0] e;
		while (q_e.size() > 0)
		begin
			m = q_m.pop_front();
			e = q_e.pop_front();
			`CHK(obs & m, e & m)
		end
	end
	initial
	begin
		int r;
		r = $urandom(17);
		tick(8);
		rst_n <= 1'b1;
		loop_duty <= 8'($urandom);
		note(9'h1ff, 9'h000);
		go(sys_normal);
		tick(4);
		note(9'h180, 9'h180);
		set_a(5, 1'b1);
		wait_idle();
		note(9'h0c0, 9'h0c0);
		$display("test soft start done");
		set_a(5, 1'b0);
		for (int i = 0; i < 6; i++)
		begin
			go(seq_m[i]);
			tick(4);
			note(seq_k[i], seq_e[i]);
		end
		set_a(5, 1'b1);
		wait_idle();
		$display("test modes done");
		go(sys_stop);
		tick(4);
		note(9'h048, 9'h000);
		set_a(4, 1'b1);
		tick(6);
		note(9'h048, 9'h048);
		set_a(4, 1'b0);
		pulse(2);
		tick(3);
		note(9'h048, 9'h008);
		set_c(4, 1'b0);
		set_a(4, 1'b1);
		tick(6);
		note(9'h040, 9'h000);
		set_a(4, 1'b0);
		set_c(3, 1'b1);
		for (int p = 1; p >= 0; p--)
		begin
			set_a(0, p[0]);
			tick(6);
			note(9'h040, {2'b00, p[0], 6'h00});
		end
		set_c(3, 1'b0);
		set_c(4, 1'b1);
		$display("test stop modulation done");
		go(sys_normal);
		set_c(5, 1'($urandom));
		set_c(6, 1'b1);
		set_a(7, 1'b1);
		tick(6);
		note(9'h030, 9'h030);
		pulse(1);
		tick(2);
		note(9'h010, 9'h010);
		set_a(7, 1'b0);
		set_a(6, 1'b1);
		tick(6);
		note(9'h020, 9'h000);
		pulse(1);
		tick(2);
		note(9'h010, 9'h000);
		set_c(6, 1'b0);
		set_a(6, 1'b0);
		set_a(7, 1'b1);
		tick(6);
		note(9'h020, 9'h000);
		set_a(7, 1'b0);
		$display("test step-up done");
		repeat (4)
		begin
			r = $urandom;
			@(posedge clk_sys) analog_in[3:1] <= {r[0], r[1], r[2]};
			tick(6);
			note(9'h0c7, 9'h0c0 | 9'(r[2:0]));
			@(posedge clk_sys) analog_in[3:1] <= 3'h0;
			tick(4);
			pulse(0);
			tick(2);
			note(9'h007, 9'h000);
		end
		$display("test status flags done");
		tick(2);
		end_of_test();
	end
endmodule
